// ==== bench/tb_ocl_regs.sv ====
// Self-checking testbench for the overcurrent limit register bank.
`timescale 1ns/1ps
`default_nettype none
module tb_ocl_regs;
  import ocl_pkg::*;
  // ----------------------------------------------------------------
  // Signals
  // ----------------------------------------------------------------
  logic aclk, aresetn, clk_en, second_current_channel, fast_result_valid;
  logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
  logic s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
  logic [11:0] s_axi_awaddr, s_axi_araddr;
  logic [31:0] s_axi_wdata, s_axi_rdata;
  logic [3:0] s_axi_wstrb;
  logic [1:0] s_axi_bresp, s_axi_rresp, rsp;
  logic [15:0] fast_result, rd;
  logic filter_run, above_limit_event, below_limit_event, overcurrent_fault_output, irq;
  int n_fail = 0;
  int samples_checked = 0;
  int cyc = 0;

  ocl_regs uut (
    .aclk, .aresetn, .clk_en, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
    .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
    .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid,
    .s_axi_rready, .second_current_channel, .fast_result, .fast_result_valid, .filter_run,
    .above_limit_event, .below_limit_event, .overcurrent_fault_output, .irq
  );

  initial begin
    aclk = 1'b0;
    forever #25 aclk = ~aclk;
  end

  // ----------------------------------------------------------------
  // Shared tasks
  // ----------------------------------------------------------------
  task automatic summarize();
    $display("comparisons %0d mismatches %0d", samples_checked, n_fail);
    if (n_fail == 0 && samples_checked > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask : summarize

  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    samples_checked++;
    if (got !== exp) begin
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
      n_fail++;
    end
  endtask : chk

  // Address and data are offered together; each is dropped once its ready was seen.
  task automatic axi_wr(input logic [9:0] idx, input logic [15:0] d, output logic [1:0] r);
    logic aw, w, b;
    @(posedge aclk);
    s_axi_awaddr <= {idx, 2'b00};
    s_axi_wdata <= {16'h0000, d};
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    aw = 1'b0;
    w = 1'b0;
    b = 1'b0;
    while (!b) begin
      @(negedge aclk);
      aw = aw || s_axi_awready;
      w = w || s_axi_wready;
      b = s_axi_bvalid;
      r = s_axi_bresp;
      @(posedge aclk);
      if (aw) s_axi_awvalid <= 1'b0;
      if (w) s_axi_wvalid <= 1'b0;
    end
    s_axi_bready <= 1'b0;
  endtask : axi_wr

  task automatic axi_rd(input logic [9:0] idx, output logic [15:0] d, output logic [1:0] r);
    logic hit;
    @(posedge aclk);
    s_axi_araddr <= {idx, 2'b00};
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    hit = 1'b0;
    while (!hit) begin
      @(negedge aclk);
      hit = s_axi_arready;
      @(posedge aclk);
    end
    s_axi_arvalid <= 1'b0;
    hit = 1'b0;
    while (!hit) begin
      @(negedge aclk);
      hit = s_axi_rvalid;
      d = s_axi_rdata[15:0];
      r = s_axi_rresp;
      @(posedge aclk);
    end
    s_axi_rready <= 1'b0;
  endtask : axi_rd

  task automatic wr(input logic [9:0] idx, input logic [15:0] d);
    axi_wr(idx, d, rsp);
    chk(16'(rsp), 16'h0000);
  endtask : wr

  task automatic rdchk(input logic [9:0] idx, input logic [15:0] exp);
    axi_rd(idx, rd, rsp);
    chk(rd, exp);
  endtask : rdchk

  // One conversion; the comparator answers at the edge that takes it.
  task automatic feed(input logic [15:0] v);
    @(posedge aclk);
    fast_result <= v;
    fast_result_valid <= 1'b1;
    @(posedge aclk);
    fast_result_valid <= 1'b0;
    @(negedge aclk);
  endtask : feed

  task automatic chk_ev(input logic [1:0] e);
    chk(16'({below_limit_event, above_limit_event}), 16'(e));
  endtask : chk_ev

  // ----------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------
  task automatic t_reset_vals();
    @(negedge aclk);
    chk(16'(overcurrent_fault_output), 16'h0001); // Inactive level with low polarity after reset.
    rdchk(IDX_UPPER, 16'h7fff); // Upper limit reset value.
    rdchk(IDX_LOWER, 16'h8000); // Lower limit reset value.
    rdchk(IDX_SPARE, 16'h5555); // Spare reset value.
    rdchk(10'h0cb, 16'h0000);
    chk(16'(rsp), 16'h0002);
    $display("test reset_vals done");
  endtask : t_reset_vals

  task automatic t_rw();
    wr(IDX_SPARE, 16'haaaa);
    rdchk(IDX_SPARE, 16'haaaa); // Spare holds what was written.
    s_axi_wstrb <= 4'h1;
    wr(IDX_SPARE, 16'h0033);
    s_axi_wstrb <= 4'hf;
    rdchk(IDX_SPARE, 16'haa33); // Only the strobed low byte lands.
    chk_ev(2'b00); // Spare has no effect on events.
    wr(IDX_UPPER, 16'h1234);
    rdchk(IDX_UPPER, 16'h1234); // Upper limit is writable.
    wr(IDX_LOWER, 16'hedcb);
    rdchk(IDX_LOWER, 16'hedcb); // Lower limit is writable.
    axi_wr(10'h0cb, 16'hffff, rsp);
    chk(16'(rsp), 16'h0002);
    $display("test rw done");
  endtask : t_rw

  task automatic t_limits();
    wr(IDX_UPPER, 16'h7fff);
    wr(IDX_LOWER, 16'h8000);
    second_current_channel <= 1'b1;
    wr(IDX_CFG, 16'hc000);
    @(negedge aclk);
    chk(16'(filter_run), 16'h0001); // Runs once enabled with channel on.
    feed(16'h7fff);
    chk_ev(2'b00); // Full-scale upper code disables the check.
    feed(16'h8000);
    chk_ev(2'b00); // Full-scale lower code disables the check.
    chk(16'(overcurrent_fault_output), 16'h0000); // Inactive level with high polarity.
    wr(IDX_UPPER, 16'h0100);
    feed(16'h0100);
    chk_ev(2'b00); // Equal is not above.
    feed(16'h0101);
    chk_ev(2'b01); // New limit applies to the next result.
    chk(16'(overcurrent_fault_output), 16'h0001); // Active level with high polarity.
    wr(IDX_UPPER, 16'hfff0);
    feed(16'h0005);
    chk_ev(2'b01); // Positive result above a negative limit.
    feed(16'hffe0);
    chk_ev(2'b00); // Signed compare.
    wr(IDX_LOWER, 16'hff00);
    feed(16'hfeff);
    chk_ev(2'b10); // Strictly below the lower limit.
    feed(16'hff00);
    chk_ev(2'b00); // Equal is not below.
    feed(16'h0001);
    chk_ev(2'b01); // Signed compare on both limits.
    $display("test limits done");
  endtask : t_limits

  task automatic t_deglitch();
    int i;
    wr(IDX_UPPER, 16'h0100);
    wr(IDX_LOWER, 16'h8000);
    wr(IDX_CFG, 16'hc200);
    feed(16'h0000);
    feed(16'h0200);
    feed(16'h0200);
    chk_ev(2'b00); // Two of the three needed is not enough.
    feed(16'h0050);
    feed(16'h0200);
    feed(16'h0200);
    chk_ev(2'b00); // Count restarted inside the limit.
    feed(16'h0200);
    chk_ev(2'b01); // Third consecutive result trips.
    wr(IDX_CFG, 16'hca00);
    feed(16'h0000);
    for (i = 1; i <= 12; i++) begin
      feed(16'h0200);
      chk_ev((i == 12) ? 2'b01 : 2'b00); // Code 01010b needs twelve.
    end
    wr(IDX_CFG, 16'hd300);
    feed(16'h0000);
    for (i = 1; i <= 32; i++) begin
      feed(16'h0200);
      chk_ev((i == 32) ? 2'b01 : 2'b00); // Code 10011b needs thirty-two.
    end
    $display("test deglitch done");
  endtask : t_deglitch

  task automatic t_irq();
    wr(IDX_CFG, 16'h8000);
    wr(IDX_MASK, 16'h0001);
    feed(16'h0000);
    axi_rd(IDX_STATUS, rd, rsp);
    @(negedge aclk);
    chk(16'(irq), 16'h0000);
    feed(16'h0200);
    chk(16'(irq), 16'h0001);
    chk(16'(overcurrent_fault_output), 16'h0000); // Active level with low polarity.
    rdchk(IDX_STATUS, 16'h0001);
    @(negedge aclk);
    chk(16'(irq), 16'h0000);
    rdchk(IDX_STATUS, 16'h0000);
    wr(IDX_MASK, 16'h0000);
    feed(16'h0000);
    feed(16'h0200);
    chk(16'(irq), 16'h0000);
    rdchk(IDX_STATUS, 16'h0001);
    rdchk(IDX_LIVE, 16'h0001);
    $display("test irq done");
  endtask : t_irq

  // A low clock enable must hold every flop, the comparator included.
  task automatic t_freeze();
    @(posedge aclk);
    clk_en <= 1'b0;
    feed(16'h0000);
    chk_ev(2'b01); // Frozen events ignore the result.
    chk(16'(overcurrent_fault_output), 16'h0000); // Fault level held while frozen.
    @(posedge aclk);
    clk_en <= 1'b1;
    feed(16'h0000);
    chk_ev(2'b00); // Result inside the limit clears once running.
    chk(16'(overcurrent_fault_output), 16'h0001); // Inactive level with low polarity.
    $display("test freeze done");
  endtask : t_freeze

  task automatic t_run_drop();
    @(posedge aclk);
    second_current_channel <= 1'b0;
    repeat (3) @(posedge aclk);
    @(negedge aclk);
    chk(16'(filter_run), 16'h0000); // Channel off stops the comparator.
    chk_ev(2'b00); // Events drop with the run.
    feed(16'h0200);
    chk_ev(2'b00); // No detection while stopped.
    @(posedge aclk);
    second_current_channel <= 1'b1;
    wr(IDX_CFG, 16'h0000);
    @(negedge aclk);
    chk(16'(filter_run), 16'h0000); // Enable bit clear keeps it stopped.
    $display("test run_drop done");
  endtask : t_run_drop

  // ----------------------------------------------------------------
  // Main sequence and hang guard
  // ----------------------------------------------------------------
  initial begin
    aresetn = 1'b0;
    clk_en = 1'b1;
    s_axi_awaddr = 12'h000;
    s_axi_awvalid = 1'b0;
    s_axi_wdata = 32'h0000_0000;
    s_axi_wstrb = 4'hf;
    s_axi_wvalid = 1'b0;
    s_axi_bready = 1'b0;
    s_axi_araddr = 12'h000;
    s_axi_arvalid = 1'b0;
    s_axi_rready = 1'b0;
    second_current_channel = 1'b0;
    fast_result = 16'h0000;
    fast_result_valid = 1'b0;
    repeat (2) @(posedge aclk);
    aresetn <= 1'b1;
    t_reset_vals();
    t_rw();
    t_limits();
    t_deglitch();
    t_irq();
    t_freeze();
    t_run_drop();
    summarize();
  end

  // The whole run needs a few hundred cycles; this ceiling only catches a stuck handshake.
  always @(posedge aclk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      n_fail++;
      summarize();
    end
  end
endmodule : tb_ocl_regs
`default_nettype wire

// ==== rtl/ocl_regs.sv ====
// Overcurrent limit registers, comparator and AXI4-Lite slave.
// Operation
// R1 - Upper limit register C8h, reset 7FFFh
// R2 - Above event when result exceeds upper limit
// R3 - Upper limit 7FFFh disables above check
// R4 - Limits and result compared as signed
// R5 - Lower limit register C9h, reset 8000h
// R6 - Below event when result under lower limit
// R7 - Lower limit 8000h disables below check
// R8 - Spare register CAh, reset 5555h
// R9 - Comparator runs only when enabled, channel on
// R10 - Trip after N consecutive exceedances, restart otherwise
// R11 - Fault output active on either event, polarity
// R12 - Spare bits are plain storage only
// R13 - New limits apply to next compared result
`timescale 1ns/1ps
`default_nettype none
module ocl_regs
  import ocl_pkg::*;
(
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic clk_en,
  input wire logic [11:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [11:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic second_current_channel,
  input wire logic [15:0] fast_result,
  input wire logic fast_result_valid,
  output logic filter_run,
  output logic above_limit_event,
  output logic below_limit_event,
  output logic overcurrent_fault_output,
  output logic irq
);
  // ----------------------------------------------------------------
  // Functions
  // ----------------------------------------------------------------
  function automatic logic [15:0] merge(input logic [15:0] old, input logic [31:0] d, input logic [3:0] s);
    logic [15:0] r;
    r = old;
    if (s[0]) begin
      r[7:0] = d[7:0];
    end
    if (s[1]) begin
      r[15:8] = d[15:8];
    end
    return r;
  endfunction : merge

  function automatic logic [CNT_W-1:0] bump(input logic [CNT_W-1:0] c);
    return (c == CNT_MAX) ? c : c + 8'h01;
  endfunction : bump

  // ----------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------
  logic [15:0] upper_r;
  logic [15:0] lower_r;
  logic [15:0] spare_r;
  logic [15:0] cfg_r;
  logic [1:0] status_r;
  logic [1:0] mask_r;
  logic [CNT_W-1:0] hi_cnt_r;
  logic [CNT_W-1:0] lo_cnt_r;
  logic above_r;
  logic below_r;
  logic fault_r;
  logic irq_r;
  logic run_r;
  logic aw_hold_r;
  logic w_hold_r;
  logic [9:0] waddr_r;
  logic [31:0] wdata_r;
  logic [3:0] wstrb_r;
  logic awready_r;
  logic wready_r;
  logic bvalid_r;
  logic [1:0] bresp_r;
  logic arready_r;
  logic rvalid_r;
  logic [31:0] rdata_r;
  logic [1:0] rresp_r;
  ocl_bus_t wr_state;

  // ----------------------------------------------------------------
  // Write channel decode
  // ----------------------------------------------------------------
  wire aw_take = s_axi_awvalid & awready_r;
  wire w_take = s_axi_wvalid & wready_r;
  wire wr_do = aw_hold_r & w_hold_r & ~bvalid_r;
  wire aw_hold_nxt = (aw_hold_r | aw_take) & ~wr_do;
  wire w_hold_nxt = (w_hold_r | w_take) & ~wr_do;
  wire bvalid_nxt = wr_do | (bvalid_r & ~s_axi_bready);
  wire wr_upper = wr_do & (waddr_r == IDX_UPPER);
  wire wr_lower = wr_do & (waddr_r == IDX_LOWER);
  wire wr_spare = wr_do & (waddr_r == IDX_SPARE);
  wire wr_cfg = wr_do & (waddr_r == IDX_CFG);
  wire wr_mask = wr_do & (waddr_r == IDX_MASK);
  wire wr_ro = wr_do & ((waddr_r == IDX_STATUS) | (waddr_r == IDX_LIVE));
  wire wr_hit = wr_upper | wr_lower | wr_spare | wr_cfg | wr_mask | wr_ro;
  wire [1:0] bresp_nxt = wr_do ? (wr_hit ? RESP_OKAY : RESP_SLVERR) : bresp_r;

  // ----------------------------------------------------------------
  // Read channel decode
  // ----------------------------------------------------------------
  wire ar_take = s_axi_arvalid & arready_r;
  wire rvalid_nxt = ar_take | (rvalid_r & ~s_axi_rready);
  wire [9:0] raddr = s_axi_araddr[11:2];
  wire rd_upper = raddr == IDX_UPPER;
  wire rd_lower = raddr == IDX_LOWER;
  wire rd_spare = raddr == IDX_SPARE;
  wire rd_cfg = raddr == IDX_CFG;
  wire rd_status = raddr == IDX_STATUS;
  wire rd_mask = raddr == IDX_MASK;
  wire rd_live = raddr == IDX_LIVE;
  wire rd_hit = rd_upper | rd_lower | rd_spare | rd_cfg | rd_status | rd_mask | rd_live;
  wire [15:0] rd_word = rd_upper ? upper_r :
                        rd_lower ? lower_r :
                        rd_spare ? spare_r :
                        rd_cfg ? cfg_r :
                        rd_status ? {14'h0000, status_r} :
                        rd_mask ? {14'h0000, mask_r} :
                        rd_live ? {14'h0000, below_r, above_r} : 16'h0000;
  wire stat_clr = ar_take & rd_status;

  // ----------------------------------------------------------------
  // Write data merge
  // ----------------------------------------------------------------
  // Registers are 16 bits wide, so only the two low strobes count and the top half word is dropped.
  wire [15:0] upper_merged = merge(upper_r, wdata_r, wstrb_r);
  wire [15:0] lower_merged = merge(lower_r, wdata_r, wstrb_r);
  wire [15:0] spare_merged = merge(spare_r, wdata_r, wstrb_r);
  wire [15:0] cfg_merged = merge(cfg_r, wdata_r, wstrb_r) & CFG_WMASK;
  wire [15:0] mask_merged = merge({14'h0000, mask_r}, wdata_r, wstrb_r);

  // ----------------------------------------------------------------
  // Comparator
  // ----------------------------------------------------------------
  // Limits feed the compare directly, so a write lands on the next result. [R13]
  wire cmp_en = cfg_r[CFG_EN_BIT];
  wire run = cmp_en & second_current_channel; // [R9]
  wire res_strobe = fast_result_valid & run;
  wire [CNT_W-1:0] need = ocl_need(cfg_r[CFG_NUM_LSB +: CFG_NUM_W]);
  wire above_hit = (upper_r != UPPER_OFF) & ($signed(fast_result) > $signed(upper_r)); // [R2] [R3] [R4]
  wire below_hit = (lower_r != LOWER_OFF) & ($signed(fast_result) < $signed(lower_r)); // [R6] [R7] [R4]
  wire [CNT_W-1:0] hi_step = bump(hi_cnt_r);
  wire [CNT_W-1:0] lo_step = bump(lo_cnt_r);
  // No hysteresis: any result back inside the limit restarts the count. [R10]
  wire [CNT_W-1:0] hi_cnt_nxt = !run ? '0 : res_strobe ? (above_hit ? hi_step : '0) : hi_cnt_r;
  wire [CNT_W-1:0] lo_cnt_nxt = !run ? '0 : res_strobe ? (below_hit ? lo_step : '0) : lo_cnt_r;
  wire above_nxt = !run ? 1'b0 : res_strobe ? (above_hit & (hi_step >= need)) : above_r; // [R10]
  wire below_nxt = !run ? 1'b0 : res_strobe ? (below_hit & (lo_step >= need)) : below_r;
  wire pol = cfg_r[CFG_POL_BIT];
  wire fault_nxt = (above_nxt | below_nxt) ? pol : ~pol; // [R11]
  // A fresh event beats a clear-on-read in the same cycle.
  wire [1:0] evt_rise = {below_nxt & ~below_r, above_nxt & ~above_r};
  wire [1:0] status_nxt = (stat_clr ? 2'b00 : status_r) | evt_rise;
  wire [1:0] mask_nxt = wr_mask ? mask_merged[1:0] : mask_r;

  // ----------------------------------------------------------------
  // Bus slave state
  // ----------------------------------------------------------------
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_hold_r <= 1'b0;
      w_hold_r <= 1'b0;
      awready_r <= 1'b0;
      wready_r <= 1'b0;
      bvalid_r <= 1'b0;
      bresp_r <= RESP_OKAY;
      waddr_r <= '0;
      wdata_r <= '0;
      wstrb_r <= '0;
      arready_r <= 1'b0;
      rvalid_r <= 1'b0;
      rdata_r <= '0;
      rresp_r <= RESP_OKAY;
      wr_state <= OCL_BUS_IDLE;
    end else if (clk_en) begin
      aw_hold_r <= aw_hold_nxt;
      w_hold_r <= w_hold_nxt;
      awready_r <= ~aw_hold_nxt & ~bvalid_nxt;
      wready_r <= ~w_hold_nxt & ~bvalid_nxt;
      bvalid_r <= bvalid_nxt;
      bresp_r <= bresp_nxt;
      if (aw_take) begin
        waddr_r <= s_axi_awaddr[11:2];
      end
      if (w_take) begin
        wdata_r <= s_axi_wdata;
        wstrb_r <= s_axi_wstrb;
      end
      arready_r <= ~rvalid_nxt;
      rvalid_r <= rvalid_nxt;
      if (ar_take) begin
        rdata_r <= {16'h0000, rd_word};
        rresp_r <= rd_hit ? RESP_OKAY : RESP_SLVERR;
      end
      case ({aw_hold_nxt, w_hold_nxt})
        2'b00: wr_state <= OCL_BUS_IDLE;
        2'b11: wr_state <= OCL_BUS_FULL;
        default: wr_state <= OCL_BUS_HALF;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // Register file
  // ----------------------------------------------------------------
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      upper_r <= UPPER_RST; // [R1]
      lower_r <= LOWER_RST; // [R5]
      spare_r <= SPARE_RST; // [R8]
      cfg_r <= CFG_RST;
      mask_r <= MASK_RST;
    end else if (clk_en) begin
      if (wr_upper) begin
        upper_r <= upper_merged; // [R1]
      end
      if (wr_lower) begin
        lower_r <= lower_merged; // [R5]
      end
      // The spare word is read back only; nothing in the block looks at it.
      if (wr_spare) begin
        spare_r <= spare_merged; // [R8] [R12]
      end
      if (wr_cfg) begin
        cfg_r <= cfg_merged;
      end
      mask_r <= mask_nxt;
    end
  end

  // ----------------------------------------------------------------
  // Comparator state and interrupt
  // ----------------------------------------------------------------
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      hi_cnt_r <= '0;
      lo_cnt_r <= '0;
      above_r <= 1'b0;
      below_r <= 1'b0;
      fault_r <= 1'b1;
      run_r <= 1'b0;
      status_r <= 2'b00;
      irq_r <= 1'b0;
    end else if (clk_en) begin
      hi_cnt_r <= hi_cnt_nxt;
      lo_cnt_r <= lo_cnt_nxt;
      above_r <= above_nxt; // [R2]
      below_r <= below_nxt; // [R6]
      fault_r <= fault_nxt; // [R11]
      run_r <= run; // [R9]
      status_r <= status_nxt;
      irq_r <= |(status_nxt & mask_nxt);
    end
  end

  assign s_axi_awready = awready_r;
  assign s_axi_wready = wready_r;
  assign s_axi_bvalid = bvalid_r;
  assign s_axi_bresp = bresp_r;
  assign s_axi_arready = arready_r;
  assign s_axi_rvalid = rvalid_r;
  assign s_axi_rdata = rdata_r;
  assign s_axi_rresp = rresp_r;
  assign filter_run = run_r;
  assign above_limit_event = above_r;
  assign below_limit_event = below_r;
  assign overcurrent_fault_output = fault_r;
  assign irq = irq_r;

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  sequence s_hit_above;
    clk_en && res_strobe && upper_r != UPPER_OFF && $signed(fast_result) > $signed(upper_r);
  endsequence
  sequence s_hit_below;
    clk_en && res_strobe && lower_r != LOWER_OFF && $signed(fast_result) < $signed(lower_r);
  endsequence
  sequence s_above_rise;
    clk_en && evt_rise[EVT_ABOVE];
  endsequence

  a_upper_reset_value: assert property ($rose(aresetn) |-> upper_r == UPPER_RST) // [R1]
    else $error("upper limit not at reset value");
  a_lower_reset_value: assert property ($rose(aresetn) |-> lower_r == LOWER_RST) // [R5]
    else $error("lower limit not at reset value");
  a_spare_reset_value: assert property ($rose(aresetn) |-> spare_r == SPARE_RST) // [R8]
    else $error("spare word not at reset value");
  a_above_trip: assert property (s_hit_above ##0 (hi_cnt_r + 8'h01 >= need) |=> above_limit_event) // [R2] [R4]
    else $error("above event did not trip");
  a_below_trip: assert property (s_hit_below ##0 (lo_cnt_r + 8'h01 >= need) |=> below_limit_event) // [R6] [R4]
    else $error("below event did not trip");
  a_upper_disabled: assert property (upper_r == UPPER_OFF && clk_en |=> !$rose(above_limit_event)) // [R3]
    else $error("above event with upper check off");
  a_lower_disabled: assert property (lower_r == LOWER_OFF && clk_en |=> !$rose(below_limit_event)) // [R7]
    else $error("below event with lower check off");
  a_idle_clears: assert property (clk_en && !run |=> !above_limit_event && !below_limit_event && !filter_run) // [R9]
    else $error("events held while comparator idle");
  a_count_restart: assert property (clk_en && res_strobe && !above_hit |=> hi_cnt_r == '0 && !above_limit_event) // [R10]
    else $error("deglitch count not restarted");
  a_fault_level: assert property (clk_en ##1 1'b1 |-> overcurrent_fault_output ==
      ((above_limit_event || below_limit_event) ? $past(pol) : !$past(pol))) // [R11]
    else $error("fault level wrong for polarity");
  a_limit_write: assert property (clk_en && wr_upper |=> upper_r == $past(upper_merged)) // [R13]
    else $error("upper limit write not applied");
  a_lower_restart: assert property (clk_en && res_strobe && !below_hit |=> lo_cnt_r == '0 && !below_limit_event) // [R10]
    else $error("low deglitch count not restarted");
  a_write_answer: assert property (wr_state == OCL_BUS_FULL && clk_en |=> s_axi_bvalid && !s_axi_awready)
    else $error("write response missing after address and data");
  a_read_answer: assert property (clk_en && ar_take |=> s_axi_rvalid && !s_axi_arready)
    else $error("read data missing after address");
  a_bad_address: assert property (clk_en && wr_do && !wr_hit |=> s_axi_bvalid && s_axi_bresp == RESP_SLVERR)
    else $error("unmapped write not refused");
  // Reset is not gated by the clock enable, so the freeze check skips the reset edge.
  a_freeze_hold: assert property (!clk_en && aresetn |=> $stable(upper_r) && $stable(above_limit_event) &&
      $stable(s_axi_bvalid) && $stable(irq))
    else $error("state moved while clock enable low");
  a_status_set: assert property (s_above_rise |=> status_r[EVT_ABOVE])
    else $error("event rise did not set status");
  a_status_sticky: assert property (clk_en && status_r[EVT_ABOVE] && !stat_clr |=> status_r[EVT_ABOVE])
    else $error("status bit lost without a read");
  a_status_clear: assert property (clk_en && stat_clr && !evt_rise[EVT_ABOVE] |=> !status_r[EVT_ABOVE])
    else $error("status bit not cleared by read");
endmodule : ocl_regs
`default_nettype wire

// ==== shared/ocl_pkg.sv ====
// Constants for the overcurrent limit register bank.
package ocl_pkg;
  // ----------------------------------------------------------------
  // Register indices; byte address is four times the index
  // ----------------------------------------------------------------
  localparam logic [9:0] IDX_UPPER = 10'h0c8;
  localparam logic [9:0] IDX_LOWER = 10'h0c9;
  localparam logic [9:0] IDX_SPARE = 10'h0ca;
  localparam logic [9:0] IDX_CFG = 10'h0d0;
  localparam logic [9:0] IDX_STATUS = 10'h0d1;
  localparam logic [9:0] IDX_MASK = 10'h0d2;
  localparam logic [9:0] IDX_LIVE = 10'h0d3;
  // ----------------------------------------------------------------
  // Reset values
  // ----------------------------------------------------------------
  localparam logic [15:0] UPPER_RST = 16'h7fff;
  localparam logic [15:0] LOWER_RST = 16'h8000;
  localparam logic [15:0] SPARE_RST = 16'h5555;
  localparam logic [15:0] CFG_RST = 16'h0000;
  localparam logic [1:0] MASK_RST = 2'h0;
  // ----------------------------------------------------------------
  // Field positions and disable codes
  // ----------------------------------------------------------------
  localparam int CFG_EN_BIT = 15;
  localparam int CFG_POL_BIT = 14;
  localparam int CFG_NUM_LSB = 8;
  localparam int CFG_NUM_W = 5;
  localparam logic [15:0] CFG_WMASK = 16'hdf00;
  localparam int EVT_ABOVE = 0;
  localparam int EVT_BELOW = 1;
  localparam logic [15:0] UPPER_OFF = 16'h7fff;
  localparam logic [15:0] LOWER_OFF = 16'h8000;
  localparam int FAST_OSR = 64;
  localparam int CNT_W = 8;
  localparam logic [CNT_W-1:0] CNT_MAX = 8'hff;
  // ----------------------------------------------------------------
  // Bus responses
  // ----------------------------------------------------------------
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  typedef enum logic [1:0] {
    OCL_BUS_IDLE = 2'b00,
    OCL_BUS_HALF = 2'b01,
    OCL_BUS_FULL = 2'b10
  } ocl_bus_t;

  // Consecutive conversions needed before an event trips.
  function automatic logic [CNT_W-1:0] ocl_need(input logic [CFG_NUM_W-1:0] sel);
    logic [CNT_W-1:0] n;
    n = 8'h01;
    if (sel < 5'h0a) begin
      n = {3'h0, sel} + 8'h01;
    end else if (sel < 5'h13) begin
      n = {2'h0, sel, 1'b0} - 8'h08;
    end else begin
      n = {sel, 3'h0} - 8'h78; // [R10]
    end
    return n;
  endfunction : ocl_need
endpackage : ocl_pkg
